// file: design/rss_datapath.sv
/*
 Rotate, subtract, set and skip execution datapath of an 8-bit core. Holds
 the working register and the four arithmetic flags. Assumes the decoder
 issues one command per cycle with the memory byte already read, writes
 mem_wr_data_out back when mem_wr_out is high, and issues nothing while
 dummy_cycle_out is high.
*/
// Overview of operation
// - Left via carry into working register.
// - Rotate memory right, flags untouched.
// - Rotate right into working register only.
// - Rotate memory right through carry.
// - Rotate right through carry into register.
// - Subtract with borrow, all four flags.
// - Subtract memory, register or memory target.
// - Subtract immediate literal from working register.
// - Decrement memory, skip when zero.
// - Decrement into register, skip when zero.
// - Skip discards prefetch, adds dummy cycle.
// - Set memory byte to all ones.
// - Set one selected bit in memory.
// - Increment memory, skip when zero.
// - Increment into register, skip when zero.
// - Skip when selected bit is one.
`timescale 1ns/1ps
`default_nettype none
module rss_datapath
   import rss_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic cmd_valid_in,
   input wire rss_cmd_t cmd_in,
   output logic [7:0] working_register_out,
   output rss_flags_t flags_out,
   output logic mem_wr_out,
   output logic [7:0] mem_wr_data_out,
   output logic discard_out,
   output logic dummy_cycle_out
);
   logic [7:0] wreg_q;
   logic [7:0] wreg_d;
   rss_flags_t flags_q;
   rss_flags_t flags_d;
   logic mem_wr_q;
   logic mem_wr_d;
   logic [7:0] mem_data_q;
   logic [7:0] mem_data_d;
   rss_res_t res;
   logic [7:0] sub_b;
   logic sub_cin;
   logic [7:0] sub_sum;
   logic sub_cout;
   logic sub_half;
   logic sub_wrap;
   logic [7:0] m;
   logic [7:0] bit_mask;
   logic go;
   logic busy;

   assign m = cmd_in.mem_data;
   assign go = cmd_valid_in && !busy;

   // Borrow input: carry flag for the borrow forms, 1 for plain subtract.
   always_comb begin
      sub_b = m;
      sub_cin = 1'b1;
      if (cmd_in.op == RSS_OP_SUB_I) begin
         sub_b = cmd_in.literal;
      end
      if ((cmd_in.op == RSS_OP_SBC_W) || (cmd_in.op == RSS_OP_SBC_M)) begin
         sub_cin = flags_q.carry_flag;
      end
   end

   rss_subtractor u_sub (
      .a_in(wreg_q),
      .b_in(sub_b),
      .cin_in(sub_cin),
      .sum_out(sub_sum),
      .cout_out(sub_cout),
      .half_out(sub_half),
      .wrap_out(sub_wrap)
   );

   // One-hot mask from the three-bit index.
   genvar gi;
   generate
      for (gi = 0; gi < RSS_DATA_W; gi++) begin : g_mask
         assign bit_mask[gi] = (cmd_in.bit_idx == 3'(gi));
      end
   endgenerate

   always_comb begin
      res = '0;
      res.value = m;
      unique case (cmd_in.op)
         RSS_OP_NONE: begin
            res.value = m;
         end
         RSS_OP_ROTATE_LEFT_VIA_FLAG_TO_WREG: begin
            res.value = {m[6:0], flags_q.carry_flag};
            res.carry = m[RSS_MSB];
            res.upd_carry = 1'b1;
            res.wr_wreg = 1'b1;
         end
         RSS_OP_RR: begin
            res.value = {m[RSS_LSB], m[7:1]};
            res.wr_mem = 1'b1;
         end
         RSS_OP_RRA: begin
            res.value = {m[RSS_LSB], m[7:1]};
            res.wr_wreg = 1'b1;
         end
         RSS_OP_RRC: begin
            res.value = {flags_q.carry_flag, m[7:1]};
            res.carry = m[RSS_LSB];
            res.upd_carry = 1'b1;
            res.wr_mem = 1'b1;
         end
         RSS_OP_ROTATE_RIGHT_VIA_FLAG_TO_WREG: begin
            res.value = {flags_q.carry_flag, m[7:1]};
            res.carry = m[RSS_LSB];
            res.upd_carry = 1'b1;
            res.wr_wreg = 1'b1;
         end
         RSS_OP_SBC_W, RSS_OP_SUB_W, RSS_OP_SUB_I: begin
            res.value = sub_sum;
            res.upd_arith = 1'b1;
            res.wr_wreg = 1'b1;
         end
         RSS_OP_SBC_M, RSS_OP_SUB_M: begin
            res.value = sub_sum;
            res.upd_arith = 1'b1;
            res.wr_mem = 1'b1;
         end
         RSS_OP_DEC_SKIP: begin
            res.value = m - RSS_ONE;
            res.wr_mem = 1'b1;
            res.skip = (res.value == RSS_ZERO);
         end
         RSS_OP_DEC_W_SKIP: begin
            res.value = m - RSS_ONE;
            res.wr_wreg = 1'b1;
            res.skip = (res.value == RSS_ZERO);
         end
         RSS_OP_SET_ALL: begin
            res.value = RSS_ALL_ONES;
            res.wr_mem = 1'b1;
         end
         RSS_OP_SET_BIT: begin
            res.value = m | bit_mask;
            res.wr_mem = 1'b1;
         end
         RSS_OP_INC_SKIP: begin
            res.value = m + RSS_ONE;
            res.wr_mem = 1'b1;
            res.skip = (res.value == RSS_ZERO);
         end
         RSS_OP_INC_W_SKIP: begin
            res.value = m + RSS_ONE;
            res.wr_wreg = 1'b1;
            res.skip = (res.value == RSS_ZERO);
         end
         RSS_OP_BIT_SKIP: begin
            res.skip = |(m & bit_mask);
         end
         default: begin
            res.value = m;
         end
      endcase
   end

   // Commands presented during the dummy cycle are ignored, so no state moves.
   always_comb begin
      wreg_d = wreg_q;
      flags_d = flags_q;
      mem_wr_d = 1'b0;
      mem_data_d = mem_data_q;
      if (go) begin
         if (res.wr_wreg) begin
            wreg_d = res.value;
         end
         if (res.wr_mem) begin
            mem_wr_d = 1'b1;
            mem_data_d = res.value;
         end
         if (res.upd_carry) begin
            flags_d.carry_flag = res.carry;
         end
         if (res.upd_arith) begin
            flags_d.carry_flag = sub_cout;
            flags_d.nibble_carry_flag = sub_half;
            flags_d.signed_wrap_flag = sub_wrap;
            flags_d.zero_flag = (sub_sum == RSS_ZERO);
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wreg_q <= RSS_WREG_RST;
         flags_q <= {4{RSS_FLAG_RST}};
         mem_wr_q <= 1'b0;
         mem_data_q <= RSS_ZERO;
      end else begin
         wreg_q <= wreg_d;
         flags_q <= flags_d;
         mem_wr_q <= mem_wr_d;
         mem_data_q <= mem_data_d;
      end
   end

   rss_skip_ctrl u_skip (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .skip_in(cmd_valid_in && res.skip),
      .discard_out(discard_out),
      .busy_out(busy)
   );

   assign dummy_cycle_out = busy;
   assign working_register_out = wreg_q;
   assign flags_out = flags_q;
   assign mem_wr_out = mem_wr_q;
   assign mem_wr_data_out = mem_data_q;

   a_rr_flags_kept: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_RR) |=> (flags_out == $past(flags_q))
         && mem_wr_out && mem_wr_data_out == {$past(m[0]), $past(m[7:1])})
      else $error("Right rotate of memory wrong or flags moved.");
   a_rrc_carry_in: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_RRC) |=> flags_out.carry_flag == $past(m[0])
         && mem_wr_data_out[7] == $past(flags_q.carry_flag))
      else $error("Rotate through carry exchanged bits wrongly.");
   a_rotate_left_via_flag_to_wreg_wreg: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_ROTATE_LEFT_VIA_FLAG_TO_WREG) |=> !mem_wr_out
         && working_register_out == {$past(m[6:0]), $past(flags_q.carry_flag)})
      else $error("Left rotate into working register wrong.");
   a_rra_no_mem: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_RRA) |=> !mem_wr_out && flags_out == $past(flags_q))
      else $error("Right rotate to register touched memory or flags.");
   a_sub_result: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_SUB_W) |=>
         working_register_out == 8'($past(wreg_q) - $past(m)))
      else $error("Subtract result wrong.");
   a_sub_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_SUB_I) |=>
         flags_out.zero_flag == (working_register_out == 8'h00))
      else $error("Zero flag disagrees with result.");
   a_dec_skip: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_DEC_SKIP && m == 8'h01) |-> discard_out
         ##1 mem_wr_data_out == 8'h00 && dummy_cycle_out)
      else $error("Decrement to zero did not skip.");
   a_set_all: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_SET_ALL) |=> mem_wr_out && mem_wr_data_out == 8'hFF)
      else $error("Set all did not write ones.");
   a_bit_skip: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_BIT_SKIP) |-> discard_out == m[cmd_in.bit_idx])
      else $error("Bit test skip wrong.");

   // A skip must cost exactly one extra cycle, never more, or issue would stall.
   sequence s_dummy_then_run;
      dummy_cycle_out ##1 !dummy_cycle_out;
   endsequence
   a_skip_two_cycles: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && res.skip) |-> discard_out ##1 s_dummy_then_run)
      else $error("Skip did not take two cycles.");
   a_plain_one_cycle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && !res.skip) |-> !discard_out ##1 !dummy_cycle_out)
      else $error("Command without skip added a cycle.");
   a_rotate_right_via_flag_to_wreg_wreg: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_ROTATE_RIGHT_VIA_FLAG_TO_WREG) |=> !mem_wr_out
         && working_register_out == {$past(flags_q.carry_flag), $past(m[7:1])}
         && flags_out.carry_flag == $past(m[0]))
      else $error("Right rotate through carry to register wrong.");
   a_sbc_result: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_SBC_W) |=> working_register_out
         == 8'($past(wreg_q) + ~$past(m) + {7'h00, $past(flags_q.carry_flag)}))
      else $error("Subtract with borrow result wrong.");
   a_minus_to_mem_op_mem: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_SUB_M) |=> mem_wr_out
         && mem_wr_data_out == 8'($past(wreg_q) - $past(m))
         && working_register_out == $past(wreg_q))
      else $error("Subtract to memory wrong.");
   a_dec_w_keep: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_DEC_W_SKIP) |=> !mem_wr_out
         && working_register_out == 8'($past(m) - 8'h01) && flags_out == $past(flags_q))
      else $error("Decrement to register wrong.");
   a_set_bit: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_SET_BIT) |=> mem_wr_out && flags_out == $past(flags_q)
         && mem_wr_data_out == ($past(m) | (8'h01 << $past(cmd_in.bit_idx))))
      else $error("Set bit wrote the wrong byte.");
   a_inc_mem: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_INC_SKIP) |=> mem_wr_out && flags_out == $past(flags_q)
         && mem_wr_data_out == 8'($past(m) + 8'h01))
      else $error("Increment of memory wrong.");
   a_inc_w_keep: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (go && cmd_in.op == RSS_OP_INC_W_SKIP) |=> !mem_wr_out
         && working_register_out == 8'($past(m) + 8'h01) && flags_out == $past(flags_q))
      else $error("Increment to register wrong.");
endmodule
`default_nettype wire

// file: design/rss_pkg.sv
/*
 Package for the rotate, subtract and skip datapath: opcodes, flag layout,
 result carriers and reset values. Assumes a single-clock core around it.
*/
package rss_pkg;

   localparam int unsigned RSS_DATA_W = 8;
   localparam int unsigned RSS_BIT_W = 3;
   localparam logic [7:0] RSS_WREG_RST = 8'h00;
   localparam logic RSS_FLAG_RST = 1'b0;
   localparam logic [7:0] RSS_ALL_ONES = 8'hFF;
   localparam logic [7:0] RSS_ONE = 8'h01;
   localparam logic [7:0] RSS_ZERO = 8'h00;
   localparam int unsigned RSS_MSB = 7;
   localparam int unsigned RSS_LSB = 0;
   localparam int unsigned RSS_NIB_MSB = 3;
   localparam int unsigned RSS_SKIP_CYCLES = 2;
   localparam int unsigned RSS_PLAIN_CYCLES = 1;

   typedef enum logic [4:0] {
      RSS_OP_NONE = 5'h00,
      RSS_OP_ROTATE_LEFT_VIA_FLAG_TO_WREG = 5'h01,
      RSS_OP_RR = 5'h02,
      RSS_OP_RRA = 5'h03,
      RSS_OP_RRC = 5'h04,
      RSS_OP_ROTATE_RIGHT_VIA_FLAG_TO_WREG = 5'h05,
      RSS_OP_SBC_W = 5'h06,
      RSS_OP_SBC_M = 5'h07,
      RSS_OP_SUB_W = 5'h08,
      RSS_OP_SUB_M = 5'h09,
      RSS_OP_SUB_I = 5'h0A,
      RSS_OP_DEC_SKIP = 5'h0B,
      RSS_OP_DEC_W_SKIP = 5'h0C,
      RSS_OP_SET_ALL = 5'h0D,
      RSS_OP_SET_BIT = 5'h0E,
      RSS_OP_INC_SKIP = 5'h0F,
      RSS_OP_INC_W_SKIP = 5'h10,
      RSS_OP_BIT_SKIP = 5'h11
   } rss_op_t;

   typedef struct packed {
      rss_op_t op;
      logic [7:0] mem_data;
      logic [7:0] literal;
      logic [2:0] bit_idx;
   } rss_cmd_t;

   typedef struct packed {
      logic signed_wrap_flag;
      logic zero_flag;
      logic nibble_carry_flag;
      logic carry_flag;
   } rss_flags_t;

   typedef struct packed {
      logic [7:0] value;
      logic wr_mem;
      logic wr_wreg;
      logic upd_arith;
      logic upd_carry;
      logic carry;
      logic skip;
   } rss_res_t;

   typedef enum logic [0:0] {
      RSS_ST_RUN = 1'b0,
      RSS_ST_DUMMY = 1'b1
   } rss_state_t;

endpackage

// file: design/rss_skip_ctrl.sv
/*
 Skip sequencer: squashes the prefetched instruction and holds one dummy
 cycle. Assumes the sequencer stalls issue while busy_out is high.
*/
`timescale 1ns/1ps
`default_nettype none
module rss_skip_ctrl
   import rss_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic skip_in,
   output logic discard_out,
   output logic busy_out
);
   rss_state_t state_q;
   rss_state_t state_d;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         RSS_ST_RUN: begin
            if (skip_in) begin
               state_d = RSS_ST_DUMMY;
            end
         end
         RSS_ST_DUMMY: begin
            state_d = RSS_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_q <= RSS_ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   assign discard_out = (state_q == RSS_ST_RUN) && skip_in;
   assign busy_out = (state_q == RSS_ST_DUMMY);

   a_dummy_one_cycle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      discard_out |=> busy_out ##1 !busy_out)
      else $error("Skip did not give exactly one dummy cycle.");
endmodule
`default_nettype wire

// file: design/rss_subtractor.sv
/*
 Eight-bit adder for the subtract and subtract-with-borrow forms (decrement uses its own): a plus inverted b plus carry in.
 Assumes the caller passes the raw subtrahend; inversion happens here.
*/
`timescale 1ns/1ps
`default_nettype none
module rss_subtractor
   import rss_pkg::*;
(
   input wire logic [7:0] a_in,
   input wire logic [7:0] b_in,
   input wire logic cin_in,
   output logic [7:0] sum_out,
   output logic cout_out,
   output logic half_out,
   output logic wrap_out
);
   logic [7:0] nb;
   logic [4:0] lo;
   logic [8:0] full;

   always_comb begin
      nb = ~b_in;
      lo = {1'b0, a_in[3:0]} + {1'b0, nb[3:0]} + {4'h0, cin_in};
      full = {1'b0, a_in} + {1'b0, nb} + {8'h00, cin_in};
      sum_out = full[7:0];
      cout_out = full[8];
      half_out = lo[4];
      // Signed wrap when both operands share a sign the result lacks.
      wrap_out = (a_in[7] == nb[7]) && (full[7] != a_in[7]);
   end
endmodule
`default_nettype wire

// file: dv/rss_datapath_test.sv
/*
 Self-checking bench for the rotate, subtract and skip datapath.
 Assumes the 40 MHz clock and the partner memory model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module rss_datapath_test;
   import rss_pkg::*;
   logic ref_clk_in;
   logic rst_in;
   logic cmd_valid_in;
   rss_cmd_t cmd_in;
   logic [7:0] working_register_out;
   rss_flags_t flags_out;
   logic mem_wr_out;
   logic [7:0] mem_wr_data_out;
   logic discard_out;
   logic dummy_cycle_out;
   logic [7:0] mem_byte;
   logic [7:0] exp_w;
   logic [3:0] exp_f;
   int mismatches;
   int total_checks;

   rss_datapath dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
      .working_register_out(working_register_out), .flags_out(flags_out),
      .mem_wr_out(mem_wr_out), .mem_wr_data_out(mem_wr_data_out),
      .discard_out(discard_out), .dummy_cycle_out(dummy_cycle_out));
   rss_mem_model partner (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .mem_wr_in(mem_wr_out), .wr_data_in(mem_wr_data_out), .byte_out(mem_byte));

   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Expected results are worked out here; a skip also offers a stray command
   // in the dummy cycle, which must be ignored.
   task automatic exec(input rss_op_t op, input logic [7:0] m, input logic [7:0] lit,
         input logic [2:0] b);
      logic [8:0] s;
      logic [4:0] n;
      logic [7:0] bb;
      logic [7:0] wd;
      logic wr;
      logic sk;
      logic ci;
      wr = 1'b0;
      sk = 1'b0;
      wd = 8'h00;
      case (op)
         RSS_OP_ROTATE_LEFT_VIA_FLAG_TO_WREG: begin
            exp_w = {m[6:0], exp_f[0]};
            exp_f[0] = m[7];
         end
         RSS_OP_RR: begin
            wr = 1'b1;
            wd = {m[0], m[7:1]};
         end
         RSS_OP_RRA: exp_w = {m[0], m[7:1]};
         RSS_OP_RRC, RSS_OP_ROTATE_RIGHT_VIA_FLAG_TO_WREG: begin
            wr = (op == RSS_OP_RRC);
            wd = {exp_f[0], m[7:1]};
            if (!wr) exp_w = wd;
            exp_f[0] = m[0];
         end
         RSS_OP_DEC_SKIP, RSS_OP_DEC_W_SKIP, RSS_OP_INC_SKIP, RSS_OP_INC_W_SKIP: begin
            wd = (op == RSS_OP_DEC_SKIP || op == RSS_OP_DEC_W_SKIP) ? m - 8'h01 : m + 8'h01;
            wr = (op == RSS_OP_DEC_SKIP || op == RSS_OP_INC_SKIP);
            sk = (wd == 8'h00);
            if (!wr) exp_w = wd;
         end
         RSS_OP_SET_ALL: begin
            wr = 1'b1;
            wd = 8'hFF;
         end
         RSS_OP_SET_BIT: begin
            wr = 1'b1;
            wd = m | (8'h01 << b);
         end
         RSS_OP_BIT_SKIP: sk = m[b];
         default: begin
            bb = (op == RSS_OP_SUB_I) ? lit : m;
            ci = (op == RSS_OP_SBC_W || op == RSS_OP_SBC_M) ? exp_f[0] : 1'b1;
            s = {1'b0, exp_w} + {1'b0, ~bb} + {8'h00, ci};
            n = {1'b0, exp_w[3:0]} + {1'b0, ~bb[3:0]} + {4'h0, ci};
            exp_f = {(exp_w[7] != bb[7]) && (s[7] != exp_w[7]), s[7:0] == 8'h00, n[4], s[8]};
            wr = (op == RSS_OP_SBC_M || op == RSS_OP_SUB_M);
            wd = s[7:0];
            if (!wr) exp_w = s[7:0];
         end
      endcase
      @(posedge ref_clk_in);
      cmd_valid_in <= 1'b1;
      cmd_in <= '{op: op, mem_data: m, literal: lit, bit_idx: b};
      #1 chk({7'h00, discard_out}, {7'h00, sk});
      @(posedge ref_clk_in);
      cmd_valid_in <= sk;
      cmd_in.op <= RSS_OP_SET_ALL;
      #1 chk(working_register_out, exp_w);
      chk({4'h0, flags_out}, {4'h0, exp_f});
      chk({7'h00, mem_wr_out}, {7'h00, wr});
      if (wr) chk(mem_wr_data_out, wd);
      chk({7'h00, dummy_cycle_out}, {7'h00, sk});
      @(posedge ref_clk_in);
      cmd_valid_in <= 1'b0;
      #1 chk({6'h00, mem_wr_out, dummy_cycle_out}, 8'h00);
      if (wr) chk(mem_byte, wd);
      chk(working_register_out, exp_w);
      $display("test %s done", op.name());
   endtask

   initial begin
      rst_in = 1'b1;
      cmd_valid_in = 1'b0;
      cmd_in = '0;
      mismatches = 0;
      total_checks = 0;
      exp_w = RSS_WREG_RST;
      exp_f = 4'h0;
      repeat (10) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      #1 chk(working_register_out, RSS_WREG_RST);
      chk({4'h0, flags_out}, 8'h00);
      exec(RSS_OP_INC_W_SKIP, 8'h7F, 8'h00, 3'h0);
      exec(RSS_OP_SUB_I, 8'h00, 8'h01, 3'h0);
      exec(RSS_OP_ROTATE_LEFT_VIA_FLAG_TO_WREG, 8'h81, 8'h00, 3'h0);
      exec(RSS_OP_RR, 8'h01, 8'h00, 3'h0);
      exec(RSS_OP_RRA, 8'h02, 8'h00, 3'h0);
      exec(RSS_OP_RRC, 8'h01, 8'h00, 3'h0);
      exec(RSS_OP_ROTATE_RIGHT_VIA_FLAG_TO_WREG, 8'h00, 8'h00, 3'h0);
      exec(RSS_OP_SBC_W, 8'h80, 8'h00, 3'h0);
      exec(RSS_OP_SBC_M, 8'hFF, 8'h00, 3'h0);
      exec(RSS_OP_SUB_W, 8'hFF, 8'h00, 3'h0);
      exec(RSS_OP_SUB_M, 8'h01, 8'h00, 3'h0);
      exec(RSS_OP_DEC_SKIP, 8'h01, 8'h00, 3'h0);
      exec(RSS_OP_DEC_W_SKIP, 8'h00, 8'h00, 3'h0);
      exec(RSS_OP_DEC_W_SKIP, 8'h01, 8'h00, 3'h0);
      exec(RSS_OP_SET_ALL, 8'h12, 8'h00, 3'h0);
      exec(RSS_OP_SET_BIT, 8'h00, 8'h00, 3'h7);
      exec(RSS_OP_INC_SKIP, 8'hFF, 8'h00, 3'h0);
      exec(RSS_OP_INC_W_SKIP, 8'hFF, 8'h00, 3'h0);
      exec(RSS_OP_BIT_SKIP, 8'h08, 8'h00, 3'h3);
      exec(RSS_OP_BIT_SKIP, 8'hF7, 8'h00, 3'h3);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// file: dv/rss_mem_model.sv
/*
 Partner model: the addressed data memory byte behind the datapath.
 Assumes one write pulse per cycle from the datapath, stored at the edge.
*/
`timescale 1ns/1ps
`default_nettype none
module rss_mem_model (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic mem_wr_in,
   input wire logic [7:0] wr_data_in,
   output logic [7:0] byte_out
);
   // The byte is only written on a pulse, so a missing pulse shows up; a repeated pulse rewrites the same held byte.
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         byte_out <= 8'h00;
      end else if (mem_wr_in) begin
         byte_out <= wr_data_in;
      end
   end
endmodule
`default_nettype wire
